// ---- inc/sce_pkg.sv ----
package sce_pkg;
	// ==========================================
	// opcode patterns (16-bit instruction word)
	localparam logic [9:0]  OP_REVSUB     = 10'h109; // 0100001001
	localparam logic [9:0]  OP_SUBBORROW  = 10'h106; // 0100000110
	localparam logic [15:0] OP_SENDEVENT  = 16'hBF40;
	localparam logic [4:0]  OP_STMULTI    = 5'h18;   // 11000
	localparam logic [4:0]  OP_STWORD_IMM = 5'h0C;   // 01100
	localparam logic [4:0]  OP_STWORD_SP  = 5'h12;   // 10010
	localparam logic [6:0]  OP_STWORD_REG = 7'h28;   // 0101000
	// ==========================================
	// architectural constants
	localparam logic [3:0]  SP_INDEX      = 4'hD;
	localparam logic [31:0] REVSUB_IMM    = 32'h0000_0000;
	localparam logic [31:0] WORD_STEP     = 32'h0000_0004;
	localparam int          LOW_REGS      = 8;
	localparam int          NUM_REGS      = 16;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} sce_flags_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
	} sce_store_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_MULTI = 3'b010,
		ST_DONE  = 3'b100
	} sce_state_type;
endpackage : sce_pkg

// ---- hdl/sce_adder.sv ----
`timescale 1ns/1ps
`default_nettype none
// 32-bit add with carry-in and full nzcv
module sce_adder
	import sce_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] i_a,
	input  wire logic [WIDTH-1:0] i_b,
	input  wire logic             i_cin,
	output logic      [WIDTH-1:0] o_sum,
	output sce_flags_type         o_flags
);
	initial begin
		if (WIDTH != 32) $error("sce_adder: width must be 32");
	end
	logic [WIDTH:0] wide;
	// ==========================================
	// sum and flags
	assign wide          = {1'b0, i_a} + {1'b0, i_b} + {{WIDTH{1'b0}}, i_cin};
	assign o_sum         = wide[WIDTH-1:0];
	assign o_flags.n     = wide[WIDTH-1];
	assign o_flags.z     = (wide[WIDTH-1:0] == '0);
	assign o_flags.c     = wide[WIDTH];
	// signed overflow: operands agree in sign, result differs
	assign o_flags.v     = (i_a[WIDTH-1] == i_b[WIDTH-1]) && (wide[WIDTH-1] != i_a[WIDTH-1]);
endmodule : sce_adder
`default_nettype wire

// ---- hdl/sce_lowest.sv ----
`timescale 1ns/1ps
`default_nettype none
// lowest set bit finder and population count
module sce_lowest
	import sce_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0]         i_bits,
	output logic      [$clog2(WIDTH)-1:0] o_index,
	output logic      [$clog2(WIDTH):0]   o_count
);
	initial begin
		if (WIDTH < 2) $error("sce_lowest: width too small");
	end
	// ==========================================
	// priority scan from the top so the lowest wins
	always_comb begin
		o_index = '0;
		o_count = '0;
		for (int k = WIDTH - 1; k >= 0; k--) begin
			if (i_bits[k]) begin
				o_index = k[$clog2(WIDTH)-1:0];
			end
			o_count = o_count + {{$clog2(WIDTH){1'b0}}, i_bits[k]};
		end
	end
endmodule : sce_lowest
`default_nettype wire

// ---- hdl/sce_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reverse subtract takes a fixed zero immediate, computing zero minus the operand register.
// - reverse subtract adds the inverted operand, the immediate and a carry-in of one, writing the destination.
// - flag-setting subtracts take n from bit 31, z on zero result, c from carry-out, v from signed overflow.
// - subtract_borrow adds operand one, the inverted unshifted operand two and the carry flag.
// - in subtract_borrow one three-bit field is destination and first source, another picks operand two.
// - send_event_hint pulses an event out to every processor.
// - send_event_hint has no other architectural effect and may act as a no-operation.
// - store_multiple zero-extends the eight-bit list so only r0-r7 are stored; writeback always on.
// - an empty store_multiple list is unpredictable; this block just writes the base back unchanged.
// - store_multiple writes selected registers lowest first at ascending word addresses from the base.
// - store_multiple writes the base plus four times the register count back to the base register.
// - a selected base that is not the lowest selected register stores an unknown value.
// - store_word general form scales the five-bit field by four, offsets 0 to 124.
// - store_word stack form uses register 13 as base and scales the eight-bit field by four, up to 1020.
// - store_word immediate writes the full source word at base plus offset; no base update.
// - store_word register form writes the source word at base plus the unshifted offset register.
module sce_exec
	import sce_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_instr_valid,
	input  wire logic [15:0] i_instr,
	input  wire logic        i_cond_pass,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_store_valid,
	output logic      [31:0] o_store_addr,
	output logic      [31:0] o_store_data,
	output logic             o_send_event,
	output logic      [3:0]  o_flags,
	output logic      [31:0] o_dbg_reg_data,
	input  wire logic [3:0]  i_dbg_reg_sel,
	input  wire logic        i_dbg_wr,
	input  wire logic [31:0] i_dbg_wr_data
);
	// ==========================================
	// register file and flags
	logic [31:0]   regs [NUM_REGS];
	sce_flags_type program_status_flags;
	sce_state_type state;

	// ==========================================
	// field extraction
	logic [2:0] second_operand_field;
	logic [2:0] base_reg_field;
	logic [2:0] source_data_field;
	logic [4:0] short_offset_field;
	logic [7:0] sp_offset_field;
	logic [7:0] list_field;
	logic [2:0] mid_reg_field;
	assign second_operand_field = i_instr[5:3];
	assign base_reg_field       = i_instr[5:3];
	assign source_data_field    = i_instr[2:0];
	assign short_offset_field   = i_instr[10:6];
	assign sp_offset_field      = i_instr[7:0];
	assign list_field           = i_instr[7:0];
	assign mid_reg_field        = i_instr[10:8];

	// ==========================================
	// decode
	logic is_revsub;
	logic is_subborrow;
	logic is_sendevent;
	logic is_stmulti;
	logic is_stimm;
	logic is_stsp;
	logic is_streg;
	logic go;
	assign go           = i_instr_valid && i_cond_pass && state == ST_IDLE;
	assign is_revsub    = go && i_instr[15:6] == OP_REVSUB;
	assign is_subborrow = go && i_instr[15:6] == OP_SUBBORROW;
	assign is_sendevent = go && i_instr == OP_SENDEVENT;
	assign is_stmulti   = go && i_instr[15:11] == OP_STMULTI;
	assign is_stimm     = go && i_instr[15:11] == OP_STWORD_IMM;
	assign is_stsp      = go && i_instr[15:11] == OP_STWORD_SP;
	assign is_streg     = go && i_instr[15:9] == OP_STWORD_REG;

	// ==========================================
	// subtract datapath: both forms share one adder
	logic [31:0]   add_a;
	logic [31:0]   add_b;
	logic          add_cin;
	logic [31:0]   sum;
	sce_flags_type add_flags;
	always_comb begin
		if (is_revsub) begin
			add_a   = ~regs[{1'b0, second_operand_field}];
			add_b   = REVSUB_IMM;
			add_cin = 1'b1;
		end else begin
			add_a   = regs[{1'b0, source_data_field}];
			add_b   = ~regs[{1'b0, second_operand_field}];
			add_cin = program_status_flags.c;
		end
	end

	sce_adder #(
		.WIDTH(32)
	) u_adder (
		.i_a    (add_a),
		.i_b    (add_b),
		.i_cin  (add_cin),
		.o_sum  (sum),
		.o_flags(add_flags)
	);

	// ==========================================
	// store_multiple sequencing state
	logic [7:0]  pending;
	logic [7:0]  list_orig;
	logic [2:0]  mbase;
	logic [31:0] maddr;
	logic [31:0] mbase_final;
	logic [2:0]  low_idx;
	logic [3:0]  low_cnt;
	logic [2:0]  first_idx;
	logic [3:0]  list_cnt;
	logic [2:0]  list_low;

	// lowest pending register to store next
	sce_lowest #(
		.WIDTH(LOW_REGS)
	) u_pend (
		.i_bits (pending),
		.o_index(low_idx),
		.o_count(low_cnt)
	);

	// count and lowest of the fresh list; the count feeds writeback, the lowest goes unused
	sce_lowest #(
		.WIDTH(LOW_REGS)
	) u_list (
		.i_bits (list_field),
		.o_index(list_low),
		.o_count(list_cnt)
	);
	assign first_idx = list_low;

	// ==========================================
	// sequencer: one word store per cycle during store_multiple
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state       <= ST_IDLE;
			pending     <= '0;
			list_orig   <= '0;
			mbase       <= '0;
			maddr       <= '0;
			mbase_final <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (is_stmulti) begin
						pending     <= list_field;
						list_orig   <= list_field;
						mbase       <= mid_reg_field;
						maddr       <= regs[{1'b0, mid_reg_field}];
						// final base: original plus four per register
						mbase_final <= regs[{1'b0, mid_reg_field}]
							+ {26'h0, list_cnt, 2'h0};
						// an empty list goes straight to writeback
						state       <= (list_field == '0) ? ST_DONE : ST_MULTI;
					end
				end
				ST_MULTI: begin
					pending <= pending & ~(8'h01 << low_idx);
					maddr   <= maddr + WORD_STEP;
					if (low_cnt == 4'h1) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// register file and flag updates
	logic [2:0] list_lowest_orig;
	sce_lowest #(
		.WIDTH(LOW_REGS)
	) u_orig (
		.i_bits (list_orig),
		.o_index(list_lowest_orig),
		.o_count()
	);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < NUM_REGS; k++) begin
				regs[k] <= '0;
			end
		end else if (i_dbg_wr && state == ST_IDLE) begin
			// software seeding of the register file while idle
			regs[i_dbg_reg_sel] <= i_dbg_wr_data;
		end else if (is_revsub) begin
			regs[{1'b0, source_data_field}] <= sum;
		end else if (is_subborrow) begin
			regs[{1'b0, source_data_field}] <= sum;
		end else if (state == ST_DONE) begin
			regs[{1'b0, mbase}] <= mbase_final;
		end
	end

	// flags update unconditionally on flag-setting subtracts
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			program_status_flags <= '0;
		end else if (is_revsub || is_subborrow) begin
			program_status_flags <= add_flags;
		end
	end

	// ==========================================
	// store port
	logic [31:0] st_imm_off;
	logic [31:0] st_sp_off;
	assign st_imm_off = {25'h0, short_offset_field, 2'h0};
	assign st_sp_off  = {22'h0, sp_offset_field, 2'h0};

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_store_valid <= 1'b0;
			o_store_addr  <= '0;
			o_store_data  <= '0;
		end else begin
			o_store_valid <= 1'b0;
			if (is_stimm) begin
				o_store_valid <= 1'b1;
				o_store_addr  <= regs[{1'b0, base_reg_field}] + st_imm_off;
				o_store_data  <= regs[{1'b0, source_data_field}];
			end else if (is_stsp) begin
				o_store_valid <= 1'b1;
				o_store_addr  <= regs[SP_INDEX] + st_sp_off;
				o_store_data  <= regs[{1'b0, mid_reg_field}];
			end else if (is_streg) begin
				o_store_valid <= 1'b1;
				o_store_addr  <= regs[{1'b0, base_reg_field}]
					+ regs[{1'b0, i_instr[8:6]}];
				o_store_data  <= regs[{1'b0, source_data_field}];
			end else if (state == ST_MULTI) begin
				o_store_valid <= 1'b1;
				o_store_addr  <= maddr;
				// non-lowest base: value unknown, we choose all ones
				if (low_idx == mbase && low_idx != list_lowest_orig) begin
					o_store_data <= 32'hFFFF_FFFF;
				end else begin
					o_store_data <= regs[{1'b0, low_idx}];
				end
			end
		end
	end

	// ==========================================
	// status outputs; the event pulse is the hint's only effect
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_send_event   <= 1'b0;
			o_busy         <= 1'b0;
			o_done         <= 1'b0;
			o_flags        <= '0;
			o_dbg_reg_data <= '0;
		end else begin
			o_send_event   <= is_sendevent;
			o_busy         <= (state != ST_IDLE) || is_stmulti;
			o_done         <= (state == ST_DONE);
			o_flags        <= program_status_flags;
			o_dbg_reg_data <= regs[i_dbg_reg_sel];
		end
	end
	logic unused_first;
	assign unused_first = ^first_idx;
endmodule : sce_exec
`default_nettype wire

// ---- tb/sce_exec_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module sce_exec_assertions
	import sce_pkg::*;
(
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic        i_cond_pass,
	input wire logic        i_dbg_wr,
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic        o_store_valid,
	input wire logic [31:0] o_store_addr,
	input wire logic        o_send_event,
	input wire logic [3:0]  o_flags
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// decode of what the block accepts this cycle
	logic take;
	logic is_multi;
	logic is_store;
	logic is_sub;
	logic multi_taken;
	logic sub_seen;
	logic sub_seen_d;
	// a debug write wins over a subtract's register write, so it never counts as taken
	assign take     = i_instr_valid && i_cond_pass && !i_dbg_wr && !o_busy && !o_done && !multi_taken;
	assign is_multi = i_instr[15:11] == OP_STMULTI;
	assign is_store = i_instr[15:11] == OP_STWORD_IMM || i_instr[15:11] == OP_STWORD_SP ||
		i_instr[15:9] == OP_STWORD_REG;
	assign is_sub   = i_instr[15:6] == OP_REVSUB || i_instr[15:6] == OP_SUBBORROW;
	// busy rises on the take edge itself and lags only the return to idle by one cycle
	always_ff @(posedge i_ref_clk) begin
		multi_taken <= i_rst_n && take && is_multi;
		sub_seen    <= i_rst_n && take && is_sub;
		sub_seen_d  <= i_rst_n && sub_seen;
	end
	// ==========================================
	// assertions
	sev_pulse_a: assert property (take && i_instr == OP_SENDEVENT |=> o_send_event)
		else $error("event not sent");
	sev_alone_a: assert property (o_send_event |-> !o_store_valid && !o_busy)
		else $error("event had side effect");
	store_pulse_a: assert property (take && is_store |=> o_store_valid)
		else $error("single store missing");
	refused_a: assert property (i_instr_valid && !i_cond_pass && !o_busy && !multi_taken |=>
		!o_send_event && !o_store_valid) else $error("failed condition acted");
	multi_busy_a: assert property (take && is_multi |=> o_busy [*2])
		else $error("busy not held");
	// empty list shows done two edges after the take, eight registers ten edges after
	multi_done_a: assert property (take && is_multi |-> ##[2:10] o_done)
		else $error("writeback late");
	multi_first_a: assert property (take && is_multi && i_instr[7:0] != 8'h00 |-> ##2 o_store_valid)
		else $error("first word late");
	multi_step_a: assert property (o_busy && o_store_valid && $past(o_store_valid) |->
		o_store_addr == $past(o_store_addr) + WORD_STEP) else $error("address step wrong");
	flags_source_a: assert property ($changed(o_flags) |-> sub_seen_d)
		else $error("flags moved without subtract");
	// main scenarios
	cover property (take && is_multi);
	cover property (o_done);
	cover property (o_send_event);
	cover property (i_instr_valid && !i_cond_pass);
endmodule : sce_exec_assertions
`default_nettype wire

// ---- tb/sce_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// memory and event receivers; always ready, so stores never stall
module sce_far_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_store_valid,
	input  wire logic [31:0] i_store_addr,
	input  wire logic [31:0] i_store_data,
	input  wire logic        i_send_event,
	output logic      [7:0]  o_event_count,
	output logic      [7:0]  o_store_count
);
	logic [31:0] mem [logic [31:0]];
	// ==========================================
	// word sink and event counter
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_event_count <= 8'h00;
			o_store_count <= 8'h00;
		end else begin
			if (i_store_valid) begin
				mem[i_store_addr] = i_store_data;
				o_store_count <= o_store_count + 8'h01;
			end
			if (i_send_event)
				o_event_count <= o_event_count + 8'h01;
		end
	end
endmodule : sce_far_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
	import sce_pkg::*;
;
	logic        i_ref_clk = 1'h0, i_rst_n = 1'h0, i_instr_valid = 1'h0, i_cond_pass = 1'h1, i_dbg_wr = 1'h0;
	logic [15:0] i_instr = 16'h0000;
	logic [3:0]  i_dbg_reg_sel = 4'h0, o_flags;
	logic [31:0] i_dbg_wr_data = 32'h0000_0000, o_store_addr, o_store_data, o_dbg_reg_data;
	logic        o_busy, o_done, o_store_valid, o_send_event;
	logic [7:0]  event_count, store_count;
	logic [31:0] rf [16];
	logic [3:0]  cf;
	logic [63:0] expq [$];
	int          err_count = 0, total_checks = 0, exp_events = 0, exp_stores = 0, seed = 28542, k;
	logic [2:0]  n, m, t;
	always #4 i_ref_clk = ~i_ref_clk;
	sce_exec sce_exec_inst (.i_ref_clk, .i_rst_n, .i_instr_valid, .i_instr, .i_cond_pass, .o_busy, .o_done,
		.o_store_valid, .o_store_addr, .o_store_data, .o_send_event, .o_flags, .o_dbg_reg_data, .i_dbg_reg_sel,
		.i_dbg_wr, .i_dbg_wr_data);
	sce_far_model sce_far_model_inst (.i_ref_clk, .i_rst_n, .i_store_valid(o_store_valid),
		.i_store_addr(o_store_addr), .i_store_data(o_store_data), .i_send_event(o_send_event),
		.o_event_count(event_count), .o_store_count(store_count));
	// ==========================================
	// helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (err_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// returns {n,z,c,v,sum}
	function automatic logic [35:0] addc(input logic [31:0] a, input logic [31:0] b, input logic ci);
		logic [32:0] s;
		s = {1'h0, a} + {1'h0, b} + {32'h0, ci};
		return {s[31], s[31:0] == 32'h0, s[32], a[31] == b[31] && s[31] != a[31], s[31:0]};
	endfunction : addc
	task automatic exec(input logic [15:0] w);
		i_instr_valid <= 1'h1;
		i_instr <= w;
		@(posedge i_ref_clk);
	endtask : exec
	task automatic quiet();
		i_instr_valid <= 1'h0;
		i_dbg_wr <= 1'h0;
		@(posedge i_ref_clk);
	endtask : quiet
	task automatic reg_write(input logic [3:0] r, input logic [31:0] v);
		i_dbg_wr <= 1'h1;
		i_dbg_reg_sel <= r;
		i_dbg_wr_data <= v;
		rf[r] = v;
		@(posedge i_ref_clk);
	endtask : reg_write
	// outputs read right at an edge show the value of the cycle just ended
	task automatic reg_check(input logic [3:0] r);
		i_dbg_reg_sel <= r;
		repeat (2) @(posedge i_ref_clk);
		check(64'(o_dbg_reg_data), 64'(rf[r]));
	endtask : reg_check
	task automatic sub_op(input bit rev, input logic [2:0] d, input logic [2:0] s);
		logic [35:0] r;
		r = rev ? addc(~rf[s], REVSUB_IMM, 1'h1) : addc(rf[d], ~rf[s], cf[1]);
		exec(rev ? {OP_REVSUB, s, d} : {OP_SUBBORROW, s, d});
		rf[d] = r[31:0];
		cf = r[35:32];
		quiet();
		reg_check({1'h0, d});
		check(64'(o_flags), 64'(cf));
	endtask : sub_op
	task automatic store_op(input logic [15:0] w, input logic [31:0] a, input logic [31:0] d);
		expq.push_back({a, d});
		exp_stores++;
		exec(w);
	endtask : store_op
	task automatic multi(input logic [2:0] b, input logic [7:0] list);
		logic [31:0] a;
		int lo, cnt, w;
		a = rf[b];
		lo = -1;
		cnt = 0;
		for (int i = 0; i < 8; i++) begin
			if (list[i]) begin
				if (lo < 0) lo = i;
				expq.push_back({a, (i == b && lo != i) ? 32'hFFFF_FFFF : rf[i]});
				exp_stores++;
				cnt++;
				a = a + WORD_STEP;
			end
		end
		exec({OP_STMULTI, b, list});
		exec(OP_SENDEVENT); // refused while sequencing
		// count from the edge after the take so an empty list, done two edges later, is not missed
		i_instr_valid <= 1'h0;
		for (w = 1; w < 20; w++) begin
			@(posedge i_ref_clk);
			if (o_done === 1'h1) break;
		end
		check(64'(w), 64'(cnt + 1));
		rf[b] = a;
		reg_check({1'h0, b});
	endtask : multi
	// ==========================================
	// store monitor: oldest note against each word seen
	always @(posedge i_ref_clk) begin
		if (o_store_valid === 1'h1)
			check({o_store_addr, o_store_data}, expq.size() ? expq.pop_front() : ~{o_store_addr, o_store_data});
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		err_count++;
		tally_and_finish();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		cf = 4'h0;
		for (k = 0; k < 16; k++) reg_write(k[3:0], $random(seed));
		reg_write(4'h1, 32'h0000_0000);
		reg_write(4'h2, 32'h8000_0000);
		quiet();
		sub_op(1, 3'h0, 3'h1); // zero operand gives z and c
		sub_op(1, 3'h3, 3'h2); // signed overflow
		for (k = 0; k < 6; k++) sub_op(k[0], 3'($random(seed)), 3'($random(seed)));
		for (k = 0; k < 4; k++) begin
			n = 3'($random(seed));
			m = 3'($random(seed));
			t = 3'($random(seed));
			store_op({OP_STWORD_IMM, 5'h1F - 5'(k), n, t}, rf[n] + {25'h0, 5'h1F - 5'(k), 2'h0}, rf[t]);
			store_op({OP_STWORD_SP, t, 8'hFF - 8'(k)}, rf[SP_INDEX] + {22'h0, 8'hFF - 8'(k), 2'h0}, rf[t]);
			store_op({OP_STWORD_REG, m, n, t}, rf[n] + rf[m], rf[t]);
			exec(OP_SENDEVENT);
			exp_events++;
			i_cond_pass <= 1'h0;
			exec({OP_STWORD_REG, m, n, t});
			exec(OP_SENDEVENT);
			i_cond_pass <= 1'h1;
		end
		quiet();
		multi(3'h0, 8'h06);
		multi(3'h2, 8'h06);
		multi(3'h4, 8'hF0);
		multi(3'h5, 8'hFF);
		multi(3'h3, 8'h00);
		repeat (4) @(posedge i_ref_clk);
		check(64'(expq.size()), 64'h0);
		check(64'(event_count), 64'(exp_events));
		check(64'(store_count), 64'(exp_stores));
		tally_and_finish();
	end
endmodule : testbench
bind sce_exec sce_exec_assertions sce_exec_assertions_inst (.i_ref_clk, .i_rst_n, .i_instr_valid, .i_instr,
	.i_cond_pass, .i_dbg_wr, .o_busy, .o_done, .o_store_valid, .o_store_addr, .o_send_event, .o_flags);
`default_nettype wire
